// file: test/pwf_power_flags_asserts.sv
`include "pwf_defs.vh"

module pwf_power_flags_asserts (
    input wire clock_i, // system clock
    input wire rst_n_i, // synchronous reset, active low
    input wire interval_expiry_i, // interval expiry pulse
    input wire sampling_powerup_i, // sampling power-up pulse
    input wire tx_done_i, // transmit finished pulse
    input wire temp_normal_i, // temperature in range
    input wire [5:0] state_o, // one-hot power state
    input wire cpu_clock_en_o, // processor clocked
    input wire cpu_power_o, // processor powered
    input wire osc_90k_en_o, // 90 kHz oscillator enable
    input wire tx_sm_en_o, // transmit state machine enable
    input wire restart_o, // restart pulse
    input wire wake_init_o // wake-up init pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    // Temperature is synchronised inside, so a recent low may still force thermal entry.
    reg [2:0] temp_hist_ff;
    wire temp_ok = temp_normal_i && (&temp_hist_ff);
    wire rst_src = |(state_o & 6'h3C);
    wire pwr_src = |(state_o & 6'h30);
    always @(posedge clock_i) begin
        temp_hist_ff <= {temp_hist_ff[1:0], temp_normal_i};
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    cpu_clock_a: assert property (cpu_clock_en_o == (state_o == `PWF_S_RUN))
        else $error("processor clock enable does not follow run state");
    cpu_power_a: assert property (cpu_power_o == (state_o inside {`PWF_S_RUN, `PWF_S_IDLE}))
        else $error("processor power wrong for state");
    tx_keep_a: assert property (state_o == `PWF_S_TXLP |-> osc_90k_en_o && tx_sm_en_o)
        else $error("transmitter clocks off in tx low power");
    pdn_quiet_a: assert property (pwr_src |-> !osc_90k_en_o && !tx_sm_en_o)
        else $error("blocks left running in power-down or thermal");
    txlp_hold_a: assert property ((state_o == `PWF_S_TXLP) && !interval_expiry_i && !tx_done_i
        && temp_ok |=> state_o == `PWF_S_TXLP)
        else $error("tx low power left without interval or done");
    txlp_exit_a: assert property ((state_o == `PWF_S_TXLP) && tx_done_i && temp_ok
        |-> ##1 state_o == `PWF_S_RUN)
        else $error("tx low power not left on transmit done");
    didle_exit_a: assert property ((state_o == `PWF_S_DIDLE) && sampling_powerup_i && temp_ok
        |=> state_o == `PWF_S_RUN)
        else $error("deep idle not left on sampling power-up");
    leave_run_a: assert property (($changed(state_o) && $past(state_o) != `PWF_S_RUN)
        |-> state_o inside {`PWF_S_RUN, `PWF_S_THERM})
        else $error("state entered from outside run");
    restart_src_a: assert property (restart_o |-> $past(rst_src) || $past(rst_src, 2))
        else $error("restart without powered-off origin");
    idle_keep_a: assert property (($past(state_o) == `PWF_S_IDLE && state_o == `PWF_S_RUN)
        |-> !restart_o ##1 !restart_o)
        else $error("restart pulse on idle resume");
    wake_init_a: assert property (wake_init_o |-> $past(pwr_src) || $past(pwr_src, 2))
        else $error("wake init without power-down or thermal origin");
    restart_need_a: assert property ($past(rst_src) && cpu_clock_en_o |-> restart_o)
        else $error("no restart pulse on powered-off exit");
    wake_need_a: assert property ($past(pwr_src) && cpu_clock_en_o |-> wake_init_o)
        else $error("no wake init pulse on power-down exit");

    cover property ($past(state_o) == `PWF_S_IDLE && state_o == `PWF_S_RUN);
    cover property ($past(state_o) == `PWF_S_TXLP && state_o == `PWF_S_RUN);
    cover property ($past(state_o) == `PWF_S_PDN && state_o == `PWF_S_RUN);
    cover property ($past(state_o) == `PWF_S_THERM && state_o == `PWF_S_RUN);
endmodule // pwf_power_flags_asserts

bind pwf_power_flags pwf_power_flags_asserts chk_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .interval_expiry_i(interval_expiry_i),
    .sampling_powerup_i(sampling_powerup_i), .tx_done_i(tx_done_i),
    .temp_normal_i(temp_normal_i), .state_o(state_o), .cpu_clock_en_o(cpu_clock_en_o),
    .cpu_power_o(cpu_power_o), .osc_90k_en_o(osc_90k_en_o), .tx_sm_en_o(tx_sm_en_o),
    .restart_o(restart_o), .wake_init_o(wake_init_o)
);

// file: test/pwf_power_flags_tb.sv
`include "pwf_defs.vh"
`define CHK(got, exp) \
    begin \
        checked = checked + 1; \
        if ((got) !== (exp)) begin \
            error_cnt = error_cnt + 1; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module pwf_power_flags_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic clock_i = 1'b0;
    logic rst_n_i, pin, temp, awvalid, wvalid, bready, arvalid, rready;
    logic [15:0] ev;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [5:0] state_o;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;

    pwf_power_flags dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .interval_expiry_i(ev[0]),
        .wake_input_pin_i(pin), .lf_carrier_i(ev[2]), .lf_sync_i(ev[3]),
        .lf_pattern_a_i(ev[4]), .lf_pattern_b_i(ev[5]), .lf_message_end_i(ev[6]),
        .lf_buffer_full_i(ev[7]), .timer_a_underflow_i(ev[8]), .timer_b_underflow_i(ev[9]),
        .tx_buffer_empty_i(ev[10]), .tx_shift_empty_i(ev[11]), .sampling_expiry_i(ev[12]),
        .sampling_powerup_i(ev[13]), .adc_done_i(ev[14]), .tx_done_i(ev[15]),
        .temp_normal_i(temp), .state_o(state_o), .cpu_clock_en_o(), .cpu_power_o(),
        .osc_90k_en_o(), .tx_sm_en_o(), .restart_o(), .wake_init_o(),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    always #5 clock_i = ~clock_i;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // A stuck handshake would hang the run, so the cycle ceiling ends it instead.
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_ok;
        logic w_ok;
        @(posedge clock_i);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock_i);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge clock_i);
        bready <= 1'b0;
        `CHK(bresp, (a > `PWF_ADDR_STATUS) ? `PWF_RESP_DECERR : `PWF_RESP_OKAY)
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clock_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock_i); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock_i); while (!rvalid);
        rready <= 1'b0;
        `CHK(rdata & m, e)
        `CHK(rresp, (a > `PWF_ADDR_STATUS) ? `PWF_RESP_DECERR : `PWF_RESP_OKAY)
    endtask

    task automatic pm(input logic [15:0] m);
        @(posedge clock_i);
        ev <= m;
        @(posedge clock_i);
        ev <= 16'h0000;
        step(2);
    endtask

    // Enter a low-power state, try a refused request and blocked events, then leave it.
    task automatic trip(input logic [2:0] c, input logic [5:0] st, input logic [15:0] pre,
                        input int x);
        wr(`PWF_ADDR_CTRL, {21'h0, c, 8'h01}, 4'h3);
        step(2);
        `CHK(state_o, st)
        wr(`PWF_ADDR_CTRL, {21'h0, (c == `PWF_REQ_PDN) ? `PWF_REQ_IDLE : `PWF_REQ_PDN, 8'h01}, 4'h3);
        step(2);
        `CHK(state_o, st)
        pm(pre);
        `CHK(state_o, st)
        pm(16'h0001 << x);
        `CHK(state_o, `PWF_S_RUN)
    endtask

    task automatic clr();
        wr(`PWF_ADDR_STATUS, 32'h0000_003F, 4'hF);
    endtask

    initial begin
        {rst_n_i, pin, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {ev, awaddr, araddr, wdata, wstrb} = '0;
        temp = 1'b1;
        repeat (5) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(`PWF_ADDR_STATUS, 32'h0000_0100, ALL);
        rd(`PWF_ADDR_WMASK, 32'h0000_0000, ALL);
        rd(`PWF_ADDR_RMASK, 32'h0000_0000, ALL);
        rd(8'h18, 32'h0000_0000, ALL);
        wr(8'h18, 32'h0000_00FF, 4'hF);
        $display("test reset done");
        wr(`PWF_ADDR_WMASK, 32'h0000_00FF, 4'hF);
        pm(16'h00FD);
        @(posedge clock_i);
        pin <= 1'b1;
        step(5);
        rd(`PWF_ADDR_WFLAG, 32'h0000_00FF, ALL);
        rd(`PWF_ADDR_WFLAG, 32'h0000_0000, ALL);
        rd(`PWF_ADDR_STATUS, 32'h0000_0110, ALL);
        clr();
        wr(`PWF_ADDR_WMASK, 32'h0000_0000, 4'hF);
        pm(16'h0004);
        rd(`PWF_ADDR_STATUS, 32'h0000_0110, ALL);
        rd(`PWF_ADDR_WFLAG, 32'h0000_0004, ALL);
        clr();
        $display("test wake flags done");
        pm(16'h0400);
        rd(`PWF_ADDR_RFLAG, 32'h0000_0000, ALL);
        wr(`PWF_ADDR_CTRL, 32'h0000_0001, 4'h1);
        pm(16'h1F00);
        rd(`PWF_ADDR_RFLAG, 32'h0000_001F, ALL);
        rd(`PWF_ADDR_STATUS, 32'h0000_0120, ALL);
        wr(`PWF_ADDR_RFLAG, 32'h0000_001F, 4'hF);
        clr();
        rd(`PWF_ADDR_RFLAG, 32'h0000_0000, ALL);
        wr(`PWF_ADDR_RMASK, 32'h0000_003F, 4'hF);
        pm(16'h4100);
        rd(`PWF_ADDR_STATUS, 32'h0000_0100, ALL);
        rd(`PWF_ADDR_RFLAG, 32'h0000_0001, ALL);
        wr(`PWF_ADDR_RFLAG, 32'h0000_0001, 4'hF);
        wr(`PWF_ADDR_RMASK, 32'h0000_0000, 4'hF);
        $display("test resume flags done");
        trip(`PWF_REQ_IDLE, `PWF_S_IDLE, 16'h0000, 9);
        trip(`PWF_REQ_IDLE, `PWF_S_IDLE, 16'h0000, 14);
        rd(`PWF_ADDR_STATUS, 32'h0000_0120, ALL);
        clr();
        trip(`PWF_REQ_TXLP, `PWF_S_TXLP, 16'h4004, 15);
        rd(`PWF_ADDR_WFLAG, 32'h0000_0004, ALL);
        rd(`PWF_ADDR_STATUS, 32'h0000_0138, ALL);
        clr();
        trip(`PWF_REQ_TXLP, `PWF_S_TXLP, 16'h0000, 0);
        rd(`PWF_ADDR_RFLAG, 32'h0000_0002, 32'h0000_0013);
        clr();
        trip(`PWF_REQ_DIDLE, `PWF_S_DIDLE, 16'h0100, 13);
        rd(`PWF_ADDR_RFLAG, 32'h0000_0002, ALL);
        rd(`PWF_ADDR_STATUS, 32'h0000_0104, ALL);
        clr();
        trip(`PWF_REQ_PDN, `PWF_S_PDN, 16'h0100, 0);
        rd(`PWF_ADDR_RFLAG, 32'h0000_0000, ALL);
        rd(`PWF_ADDR_STATUS, 32'h0000_0111, ALL);
        clr();
        $display("test power states done");
        @(posedge clock_i);
        temp <= 1'b0;
        step(6);
        `CHK(state_o, `PWF_S_THERM)
        pm(16'h0004);
        `CHK(state_o, `PWF_S_THERM)
        @(posedge clock_i);
        temp <= 1'b1;
        step(6);
        `CHK(state_o, `PWF_S_RUN)
        rd(`PWF_ADDR_STATUS, 32'h0000_0112, ALL);
        $display("test thermal done");
        end_sim();
    end
endmodule // pwf_power_flags_tb

// file: verilog/pwf_defs.vh
`ifndef PWF_DEFS_VH
`define PWF_DEFS_VH

// Register byte offsets.
`define PWF_ADDR_CTRL 8'h00
`define PWF_ADDR_WFLAG 8'h04
`define PWF_ADDR_WMASK 8'h08
`define PWF_ADDR_RFLAG 8'h0C
`define PWF_ADDR_RMASK 8'h10
`define PWF_ADDR_STATUS 8'h14

// Field positions.
`define PWF_CTRL_TXCPU 0
`define PWF_CTRL_REQ_LSB 8
`define PWF_CTRL_REQ_MSB 10
`define PWF_RMASK_ADC 5
`define PWF_STATUS_STATE_LSB 8
`define PWF_ST_FROM_PDN 0
`define PWF_ST_THERMAL 1
`define PWF_ST_FROM_DIDLE 2
`define PWF_ST_FROM_TXLP 3
`define PWF_ST_WAKE_PEND 4
`define PWF_ST_RES_PEND 5

// Entry request codes written to the control register.
`define PWF_REQ_IDLE 3'h1
`define PWF_REQ_DIDLE 3'h2
`define PWF_REQ_TXLP 3'h3
`define PWF_REQ_PDN 3'h4

// Reset values.
`define PWF_WMASK_RST 8'h00
`define PWF_RMASK_RST 6'h00

// Bus responses.
`define PWF_RESP_OKAY 2'h0
`define PWF_RESP_DECERR 2'h3

// Power states, one-hot.
`define PWF_S_RUN 6'h01
`define PWF_S_IDLE 6'h02
`define PWF_S_DIDLE 6'h04
`define PWF_S_TXLP 6'h08
`define PWF_S_PDN 6'h10
`define PWF_S_THERM 6'h20

`endif

// file: verilog/pwf_power_flags.v
// What this block does
// - Power-down runs nothing; only wake logic waits.
// - TX low power keeps transmitter, wakes on timer/done.
// - Thermal shutdown resumes only when temperature normal.
// - Idle halts processor; resume continues in place.
// - Deep idle powers processor off; restart at vector.
// - Thermal shutdown restarts processor at reset vector.
// - Only run state enters states, except thermal; hardware leaves them.
// - Wake events always set flags; masks gate wake only.
// - TX low power blocks all but interval wake.
// - Wake flags set everywhere; interval alone wakes TX.
// - Timer flags cleared in power-down, held in deep idle.
// - Encoder empty flags only valid in processor transmit.
// - Hidden converter flag: cleared, held, raised per state.
// - Waking from power-down sets its origin flag.
// - Thermal release sets separate thermal detect flag.
// - Deep idle and TX low power origin flags.
// - Unmasked wake event sets wake pending everywhere.
// - Unmasked resume event sets pending in TX/idle/run.
// - Wake flag register clears on read, accumulates.
// - Interval wake ignores its mask bit.
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`include "pwf_defs.vh"

module pwf_power_flags (
    input wire clock_i, // 100 MHz system clock
    input wire rst_n_i, // synchronous reset, active low
    input wire interval_expiry_i, // interval timer underflow pulse
    input wire wake_input_pin_i, // external wake pin, asynchronous
    input wire lf_carrier_i, // LF carrier detected pulse
    input wire lf_sync_i, // LF sync match pulse
    input wire lf_pattern_a_i, // LF pattern 0 match pulse
    input wire lf_pattern_b_i, // LF pattern 1 match pulse
    input wire lf_message_end_i, // LF end of message pulse
    input wire lf_buffer_full_i, // LF buffer full pulse
    input wire timer_a_underflow_i, // timer 0 underflow pulse
    input wire timer_b_underflow_i, // timer 1 underflow pulse
    input wire tx_buffer_empty_i, // encoder buffer empty pulse
    input wire tx_shift_empty_i, // encoder shift register empty pulse
    input wire sampling_expiry_i, // sampling timer elapsed pulse
    input wire sampling_powerup_i, // sampling timer power-up pulse
    input wire adc_done_i, // converter end of conversion pulse
    input wire tx_done_i, // transmit state machine finished pulse
    input wire temp_normal_i, // temperature in range, asynchronous
    output wire [5:0] state_o, // one-hot power state
    output wire cpu_clock_en_o, // processor clocked
    output wire cpu_power_o, // processor powered
    output wire osc_90k_en_o, // 90 kHz oscillator enable
    output wire tx_sm_en_o, // transmit state machine enable
    output wire restart_o, // pulse: processor starts at reset vector
    output wire wake_init_o, // pulse: registers take wake-up values
    input wire [7:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output wire s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte strobes
    input wire s_axi_wvalid, // write data valid
    output wire s_axi_wready, // write data ready
    output wire [1:0] s_axi_bresp, // write response
    output wire s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [7:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output wire s_axi_arready, // read address ready
    output wire [31:0] s_axi_rdata, // read data
    output wire [1:0] s_axi_rresp, // read response
    output wire s_axi_rvalid, // read data valid
    input wire s_axi_rready // read data ready
);

    localparam [5:0] S_RUN = `PWF_S_RUN;
    localparam [5:0] S_IDLE = `PWF_S_IDLE;
    localparam [5:0] S_DIDLE = `PWF_S_DIDLE;
    localparam [5:0] S_TXLP = `PWF_S_TXLP;
    localparam [5:0] S_PDN = `PWF_S_PDN;
    localparam [5:0] S_THERM = `PWF_S_THERM;

    reg [5:0] state_ff;
    reg [5:0] nxt_state;
    reg pin_s1_ff;
    reg pin_s2_ff;
    reg pin_s3_ff;
    reg temp_s1_ff;
    reg temp_s2_ff;
    reg [7:0] wake_event_flags_ff;
    reg [7:0] wake_mask_ff;
    reg [4:0] resume_flags_ff;
    reg [5:0] resume_mask_ff;
    reg [5:0] status_ff;
    reg [5:0] nxt_status_set;
    reg adc_pend_ff;
    reg cpu_tx_mode_ff;
    reg restart_ff;
    reg wake_init_ff;
    reg nxt_restart;
    reg nxt_wake_init;
    reg aw_hold_ff;
    reg w_hold_ff;
    reg [7:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0] rresp_ff;
    reg [31:0] rd_mux;
    reg rd_hit;

    // The pin is level-change sensitive, so both edges count as an event.
    wire pin_event = pin_s2_ff ^ pin_s3_ff;
    wire wake_powered = 1'b1;
    wire [7:0] wake_ev = {lf_buffer_full_i, lf_message_end_i, lf_pattern_b_i,
                          lf_pattern_a_i, lf_sync_i, lf_carrier_i, pin_event,
                          interval_expiry_i};
    wire [7:0] wake_gate = {~wake_mask_ff[7:1], 1'b1};
    wire [7:0] wake_unmasked = wake_ev & wake_gate;
    wire any_wake = |wake_unmasked;
    wire tx_valid = cpu_tx_mode_ff & ~(state_ff == S_TXLP);
    wire [4:0] res_ev = {sampling_expiry_i, tx_shift_empty_i & tx_valid,
                         tx_buffer_empty_i & tx_valid, timer_b_underflow_i,
                         timer_a_underflow_i};
    wire any_res = |(res_ev & ~resume_mask_ff[4:0]);
    wire adc_res = adc_pend_ff & ~resume_mask_ff[`PWF_RMASK_ADC];
    wire adc_res_now = adc_done_i & ~resume_mask_ff[`PWF_RMASK_ADC];
    wire overtemp = ~temp_s2_ff;

    wire wr_do = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    wire rd_take = s_axi_arvalid & ~rvalid_ff;
    wire wr_ctrl = wr_do & (awaddr_ff == `PWF_ADDR_CTRL);
    wire go_req = wr_ctrl & wstrb_ff[1];
    wire [2:0] req_code = wdata_ff[`PWF_CTRL_REQ_MSB:`PWF_CTRL_REQ_LSB];
    wire rd_clr_wake = rd_take & (s_axi_araddr == `PWF_ADDR_WFLAG);
    wire [4:0] rflag_w1c = (wr_do & (awaddr_ff == `PWF_ADDR_RFLAG) & wstrb_ff[0]) ?
                           wdata_ff[4:0] : 5'h00;
    wire [5:0] status_w1c = (wr_do & (awaddr_ff == `PWF_ADDR_STATUS) & wstrb_ff[0]) ?
                            wdata_ff[5:0] : 6'h00;

    // Pin and temperature synchronisers; the third pin stage only feeds the edge detector.
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
            pin_s3_ff <= 1'b0;
            temp_s1_ff <= 1'b1;
            temp_s2_ff <= 1'b1;
        end else begin
            pin_s1_ff <= wake_input_pin_i;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            temp_s1_ff <= temp_normal_i;
            temp_s2_ff <= temp_s1_ff;
        end
    end

    // Power state sequencing and the origin flags it raises.
    always @* begin
        nxt_state = state_ff;
        nxt_status_set = 6'h00;
        nxt_restart = 1'b0;
        nxt_wake_init = 1'b0;
        if (any_wake) begin
            nxt_status_set[`PWF_ST_WAKE_PEND] = 1'b1;
        end
        if ((any_res || adc_res_now) && (state_ff == S_TXLP || state_ff == S_IDLE ||
                state_ff == S_RUN)) begin
            nxt_status_set[`PWF_ST_RES_PEND] = 1'b1;
        end
        case (state_ff)
            S_RUN: begin
                if (overtemp) begin
                    nxt_state = S_THERM;
                end else if (go_req) begin
                    case (req_code)
                        `PWF_REQ_IDLE: nxt_state = S_IDLE;
                        `PWF_REQ_DIDLE: nxt_state = S_DIDLE;
                        `PWF_REQ_TXLP: nxt_state = S_TXLP;
                        `PWF_REQ_PDN: nxt_state = S_PDN;
                        default: nxt_state = S_RUN;
                    endcase
                end
            end
            S_IDLE: begin
                if (overtemp) begin
                    nxt_state = S_THERM;
                end else if (any_wake || any_res || adc_res) begin
                    nxt_state = S_RUN;
                end
            end
            S_DIDLE: begin
                if (overtemp) begin
                    nxt_state = S_THERM;
                end else if (any_wake || sampling_powerup_i) begin
                    nxt_state = S_RUN;
                    nxt_restart = 1'b1;
                    nxt_status_set[`PWF_ST_FROM_DIDLE] = 1'b1;
                end
            end
            S_TXLP: begin
                if (overtemp) begin
                    nxt_state = S_THERM;
                end else if (interval_expiry_i || tx_done_i) begin
                    nxt_state = S_RUN;
                    nxt_restart = 1'b1;
                    nxt_status_set[`PWF_ST_FROM_TXLP] = 1'b1;
                end
            end
            S_PDN: begin
                if (overtemp) begin
                    nxt_state = S_THERM;
                end else if (any_wake) begin
                    nxt_state = S_RUN;
                    nxt_restart = 1'b1;
                    nxt_wake_init = 1'b1;
                    nxt_status_set[`PWF_ST_FROM_PDN] = 1'b1;
                end
            end
            S_THERM: begin
                if (!overtemp) begin
                    nxt_state = S_RUN;
                    nxt_restart = 1'b1;
                    nxt_wake_init = 1'b1;
                    nxt_status_set[`PWF_ST_THERMAL] = 1'b1;
                    nxt_status_set[`PWF_ST_WAKE_PEND] = 1'b1;
                end
            end
            default: begin
                nxt_state = S_RUN;
            end
        endcase
    end

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_ff <= S_RUN;
            restart_ff <= 1'b0;
            wake_init_ff <= 1'b0;
            status_ff <= 6'h00;
        end else begin
            state_ff <= nxt_state;
            restart_ff <= nxt_restart;
            wake_init_ff <= nxt_wake_init;
            // A flag raised in the same cycle as its clear stays set.
            status_ff <= (status_ff & ~status_w1c) | nxt_status_set;
        end
    end

    // Event indicator flags.
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            wake_event_flags_ff <= 8'h00;
            resume_flags_ff <= 5'h00;
            adc_pend_ff <= 1'b0;
        end else begin
            // Set wins over the read clear so no event is lost.
            wake_event_flags_ff <= (wake_event_flags_ff & ~{8{rd_clr_wake}}) |
                                   (wake_ev & {8{wake_powered}});
            case (state_ff)
                S_PDN, S_THERM: begin
                    resume_flags_ff <= 5'h00;
                    adc_pend_ff <= 1'b0;
                end
                S_DIDLE: begin
                    resume_flags_ff <= resume_flags_ff & ~rflag_w1c;
                    adc_pend_ff <= adc_pend_ff;
                end
                S_TXLP: begin
                    resume_flags_ff <= resume_flags_ff & ~rflag_w1c;
                    adc_pend_ff <= adc_pend_ff | adc_done_i;
                end
                S_IDLE: begin
                    resume_flags_ff <= (resume_flags_ff & ~rflag_w1c) | res_ev;
                    adc_pend_ff <= adc_pend_ff | adc_done_i;
                end
                default: begin
                    resume_flags_ff <= (resume_flags_ff & ~rflag_w1c) | res_ev;
                    // Running code consumes the conversion, so only a fresh one is kept.
                    adc_pend_ff <= adc_done_i;
                end
            endcase
        end
    end

    // Software writable control state.
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            wake_mask_ff <= `PWF_WMASK_RST;
            resume_mask_ff <= `PWF_RMASK_RST;
            cpu_tx_mode_ff <= 1'b0;
        end else if (wr_do && wstrb_ff[0]) begin
            if (awaddr_ff == `PWF_ADDR_WMASK) begin
                wake_mask_ff <= wdata_ff[7:0];
            end
            if (awaddr_ff == `PWF_ADDR_RMASK) begin
                resume_mask_ff <= wdata_ff[5:0];
            end
            if (awaddr_ff == `PWF_ADDR_CTRL) begin
                cpu_tx_mode_ff <= wdata_ff[`PWF_CTRL_TXCPU];
            end
        end
    end

    // Write channel: address and data are caught in either order.
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `PWF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                case (awaddr_ff)
                    `PWF_ADDR_CTRL, `PWF_ADDR_WFLAG, `PWF_ADDR_WMASK, `PWF_ADDR_RFLAG,
                    `PWF_ADDR_RMASK, `PWF_ADDR_STATUS: bresp_ff <= `PWF_RESP_OKAY;
                    default: bresp_ff <= `PWF_RESP_DECERR;
                endcase
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `PWF_ADDR_CTRL: rd_mux[`PWF_CTRL_TXCPU] = cpu_tx_mode_ff;
            `PWF_ADDR_WFLAG: rd_mux[7:0] = wake_event_flags_ff;
            `PWF_ADDR_WMASK: rd_mux[7:0] = wake_mask_ff;
            `PWF_ADDR_RFLAG: rd_mux[4:0] = resume_flags_ff;
            `PWF_ADDR_RMASK: rd_mux[5:0] = resume_mask_ff;
            `PWF_ADDR_STATUS: begin
                rd_mux[5:0] = status_ff;
                rd_mux[13:8] = state_ff;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel: one cycle from the address to the data.
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `PWF_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_hit ? `PWF_RESP_OKAY : `PWF_RESP_DECERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    assign state_o = state_ff;
    assign cpu_clock_en_o = (state_ff == S_RUN);
    // The halted processor keeps power in idle so it can continue in place.
    assign cpu_power_o = (state_ff == S_RUN) | (state_ff == S_IDLE);
    assign osc_90k_en_o = (state_ff == S_RUN) | (state_ff == S_IDLE) |
                          (state_ff == S_DIDLE) | (state_ff == S_TXLP);
    assign tx_sm_en_o = (state_ff == S_RUN) | (state_ff == S_IDLE) |
                        (state_ff == S_TXLP);
    assign restart_o = restart_ff;
    assign wake_init_o = wake_init_ff;

endmodule // pwf_power_flags
